// ==== verilog/asce_pkg.sv ====
// Shared constants and types of the asynchronous serial communication element
package asce_pkg;
  // Register offsets
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  // Interrupt enable bits
  localparam int IER_RX = 0;
  localparam int IER_TX_HOLDING_EMPTY = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  // Frame format bits
  localparam int LCR_STB = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK = 6;
  localparam int LCR_DIVISOR_BANK_SELECT = 7;
  // Handshake output bits
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  // Handshake level index, ring indicator is edge-flagged
  localparam int MSR_RI = 2;
  // Interrupt source codes
  localparam logic [1:0] IID_LINE = 2'h3;
  localparam logic [1:0] IID_RXD = 2'h2;
  localparam logic [1:0] IID_TX_HOLDING_EMPTY = 2'h1;
  localparam logic [1:0] IID_MODEM = 2'h0;
  // Timing in 16x ticks, last index of a five-bit word, divisor that stops the tick
  localparam logic [5:0] TICK_BIT = 6'h10;
  localparam logic [5:0] TICK_HALF = 6'h08;
  localparam logic [5:0] TICK_ONEHALF = 6'h18;
  localparam logic [5:0] TICK_TWO = 6'h20;
  localparam logic [2:0] IDX_FIVE = 3'h4;
  localparam logic [15:0] DIV_STOP = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } asce_ser_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } asce_bus_req_t;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } asce_modem_in_t;

  typedef struct packed {
    logic [7:0] dll;
    logic [7:0] dlm;
    logic [3:0] interrupt_enable;
    logic [7:0] frame_format_control;
    logic [4:0] handshake_output_control;
    logic [7:0] scr;
    logic [15:0] baudCnt;
    logic tick;
    asce_ser_state_t txState;
    logic [5:0] txTick;
    logic [2:0] txIdx;
    logic [7:0] txShift;
    logic txPar;
    logic [7:0] transmit_holding;
    logic thrFull;
    logic txLine;
    logic threIrq;
    asce_ser_state_t rxState;
    logic [5:0] rxTick;
    logic [2:0] rxIdx;
    logic [7:0] rxShift;
    logic rxPar;
    logic rxPerr;
    logic rxAllZero;
    logic rxArmed;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [3:0] msrPrev;
    logic [3:0] delta;
    logic txdPin;
    logic dtrPin;
    logic rtsPin;
    logic out1Pin;
    logic out2Pin;
    logic irqPin;
    logic [7:0] rdata;
  } asce_top_state_t;

  localparam asce_top_state_t TOP_RST = '{
    txState: ST_IDLE,
    rxState: ST_IDLE,
    txLine: 1'b1,
    txdPin: 1'b1,
    default: '0
  };
endpackage : asce_pkg

// ==== verilog/asce_uart.sv ====
// Serial communication element: receive FIFO and register-mapped transmitter/receiver
//
// Function
// - Start, 5-8 data, parity, 1/1.5/2 stops
// - 16-bit divisor makes 16x transmit clock
// - Receiver sampled by same 16x clock
// - Bank 0: offset 0 data, 1 enables
// - Bank 1: offsets 0/1 divisor bytes
// - Offsets 2-7 fixed register order
// - Receive buffer read-only, holding write-only
// - Four interrupt enables, upper bits zero
// - Source reg: pending low, code, zeros
// - Two bits select word length
// - Stop, parity, even, stick, break bits
// - Bit 7 selects divisor bank
// - Handshake outputs and loopback bit
// - Line status flags, bit 7 zero
// - Handshake change flags and levels
// - Divisor low and high bytes combine
`timescale 1ns/10ps
`default_nettype none

module asce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } asce_fifo_state_t;
  asce_fifo_state_t s_reg;
  asce_fifo_state_t s_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nextPtr

  assign inReady = (s_reg.count != (AW + 1)'(DEPTH));
  assign outValid = (s_reg.count != '0);
  assign outData = s_reg.mem[s_reg.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wrPtr] = inData;
      s_next.wrPtr = nextPtr(s_reg.wrPtr);
    end
    if (pop) begin
      s_next.rdPtr = nextPtr(s_reg.rdPtr);
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : asce_fifo

module asce_uart #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host register port
  input wire asce_pkg::asce_bus_req_t busReq,
  output logic [7:0] busRdata,
  output logic irqOut,
  // Serial line
  output logic serialOut,
  input wire logic serialIn,
  // Handshake lines
  output logic dtrOut,
  output logic rtsOut,
  output logic out1Out,
  output logic out2Out,
  input wire asce_pkg::asce_modem_in_t modemIn
);
  asce_pkg::asce_top_state_t s_reg;
  asce_pkg::asce_top_state_t s_next;
  logic divisor_bank_select;
  logic loop;
  logic [15:0] divisor;
  logic [2:0] lastIdx;
  logic rxIn;
  logic [3:0] levels;
  logic [3:0] chg;
  logic pendLine;
  logic pendRx;
  logic pendThre;
  logic pendModem;
  logic pending;
  logic [1:0] iid;
  logic tx_shifter_empty;
  logic txEnd;
  logic rxMid;
  logic rxPush;
  logic [7:0] rxPushData;
  logic fifoPop;
  logic fifoReady;
  logic fifoValid;
  logic [7:0] fifoData;
  logic [7:0] rdVal;

  function automatic logic parityBit(input logic acc, input logic [7:0] frame_format_control);
    if (frame_format_control[asce_pkg::LCR_STICK]) begin
      parityBit = ~frame_format_control[asce_pkg::LCR_EPS];
    end else begin
      parityBit = frame_format_control[asce_pkg::LCR_EPS] ? acc : ~acc;
    end
  endfunction : parityBit

  function automatic logic [5:0] stopTicks(input logic [7:0] frame_format_control);
    if (!frame_format_control[asce_pkg::LCR_STB]) begin
      stopTicks = asce_pkg::TICK_BIT;
    end else if (frame_format_control[1:0] == 2'h0) begin
      stopTicks = asce_pkg::TICK_ONEHALF;
    end else begin
      stopTicks = asce_pkg::TICK_TWO;
    end
  endfunction : stopTicks

  asce_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) rxFifo (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(rxPush),
    .inReady(fifoReady),
    .inData(rxPushData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign divisor_bank_select = s_reg.frame_format_control[asce_pkg::LCR_DIVISOR_BANK_SELECT];
  assign loop = s_reg.handshake_output_control[asce_pkg::MCR_LOOP];
  assign divisor = {s_reg.dlm, s_reg.dll};
  assign lastIdx = asce_pkg::IDX_FIVE + {1'b0, s_reg.frame_format_control[1:0]};
  assign rxIn = loop ? s_reg.txLine : serialIn;
  assign levels = loop ? {s_reg.handshake_output_control[asce_pkg::MCR_OUT2], s_reg.handshake_output_control[asce_pkg::MCR_OUT1],
                          s_reg.handshake_output_control[asce_pkg::MCR_DTR], s_reg.handshake_output_control[asce_pkg::MCR_RTS]}
                       : modemIn;
  assign chg = ((levels ^ s_reg.msrPrev) & 4'hb)
             | ({3'h0, s_reg.msrPrev[asce_pkg::MSR_RI] & ~levels[asce_pkg::MSR_RI]} << 2);
  assign pendLine = s_reg.interrupt_enable[asce_pkg::IER_LINE] & (s_reg.oe | s_reg.pe | s_reg.fe | s_reg.bi);
  assign pendRx = s_reg.interrupt_enable[asce_pkg::IER_RX] & fifoValid;
  assign pendThre = s_reg.interrupt_enable[asce_pkg::IER_TX_HOLDING_EMPTY] & s_reg.threIrq;
  assign pendModem = s_reg.interrupt_enable[asce_pkg::IER_MODEM] & (|s_reg.delta);
  assign pending = pendLine | pendRx | pendThre | pendModem;
  assign iid = pendLine ? asce_pkg::IID_LINE
             : pendRx ? asce_pkg::IID_RXD
             : pendThre ? asce_pkg::IID_TX_HOLDING_EMPTY
             : asce_pkg::IID_MODEM;
  assign tx_shifter_empty = (s_reg.txState == asce_pkg::ST_IDLE) & ~s_reg.thrFull;
  assign txEnd = (s_reg.txTick == asce_pkg::TICK_BIT - 6'h01);
  assign rxMid = (s_reg.rxTick == asce_pkg::TICK_BIT - 6'h01);

  always_comb begin
    s_next = s_reg;
    rxPush = 1'b0;
    rxPushData = 8'h00;
    fifoPop = 1'b0;
    rdVal = 8'h00;
    s_next.tick = 1'b0;
    if (divisor == asce_pkg::DIV_STOP) begin
      s_next.baudCnt = asce_pkg::DIV_STOP;
    end else if (s_reg.baudCnt >= divisor - 16'h0001) begin
      s_next.baudCnt = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.baudCnt = s_reg.baudCnt + 16'h0001;
    end
    s_next.msrPrev = levels;
    if (busReq.rd) begin
      case (busReq.addr)
        asce_pkg::OFS_DATA: begin
          if (divisor_bank_select) begin
            rdVal = s_reg.dll;
          end else begin
            rdVal = fifoData;
            fifoPop = fifoValid;
          end
        end
        asce_pkg::OFS_IER: rdVal = divisor_bank_select ? s_reg.dlm : {4'h0, s_reg.interrupt_enable};
        asce_pkg::OFS_IIR: begin
          rdVal = {5'h00, iid, ~pending};
          if (pending && iid == asce_pkg::IID_TX_HOLDING_EMPTY) begin
            s_next.threIrq = 1'b0;
          end
        end
        asce_pkg::OFS_LCR: rdVal = s_reg.frame_format_control;
        asce_pkg::OFS_MCR: rdVal = {3'h0, s_reg.handshake_output_control};
        asce_pkg::OFS_LSR: begin
          rdVal = {1'b0, tx_shifter_empty, ~s_reg.thrFull, s_reg.bi, s_reg.fe, s_reg.pe, s_reg.oe, fifoValid};
          s_next.oe = 1'b0;
          s_next.pe = 1'b0;
          s_next.fe = 1'b0;
          s_next.bi = 1'b0;
        end
        asce_pkg::OFS_MSR: begin
          rdVal = {s_reg.msrPrev, s_reg.delta};
          s_next.delta = 4'h0;
        end
        default: rdVal = s_reg.scr;
      endcase
    end
    s_next.rdata = rdVal;
    s_next.delta = s_next.delta | chg;
    if (s_reg.tick) begin
      s_next.txTick = s_reg.txTick + 6'h01;
      case (s_reg.txState)
        asce_pkg::ST_IDLE: begin
          s_next.txTick = 6'h00;
          if (s_reg.thrFull) begin
            s_next.txShift = s_reg.transmit_holding;
            s_next.thrFull = 1'b0;
            s_next.threIrq = 1'b1;
            s_next.txState = asce_pkg::ST_START;
            s_next.txLine = 1'b0;
            s_next.txPar = 1'b0;
          end
        end
        asce_pkg::ST_START: begin
          if (txEnd) begin
            s_next.txTick = 6'h00;
            s_next.txState = asce_pkg::ST_DATA;
            s_next.txIdx = 3'h0;
            s_next.txLine = s_reg.txShift[0];
          end
        end
        asce_pkg::ST_DATA: begin
          if (txEnd) begin
            s_next.txTick = 6'h00;
            s_next.txPar = s_reg.txPar ^ s_reg.txShift[0];
            s_next.txShift = {1'b0, s_reg.txShift[7:1]};
            if (s_reg.txIdx == lastIdx) begin
              if (s_reg.frame_format_control[asce_pkg::LCR_PEN]) begin
                s_next.txState = asce_pkg::ST_PAR;
                s_next.txLine = parityBit(s_reg.txPar ^ s_reg.txShift[0], s_reg.frame_format_control);
              end else begin
                s_next.txState = asce_pkg::ST_STOP;
                s_next.txLine = 1'b1;
              end
            end else begin
              s_next.txIdx = s_reg.txIdx + 3'h1;
              s_next.txLine = s_reg.txShift[1];
            end
          end
        end
        asce_pkg::ST_PAR: begin
          if (txEnd) begin
            s_next.txTick = 6'h00;
            s_next.txState = asce_pkg::ST_STOP;
            s_next.txLine = 1'b1;
          end
        end
        asce_pkg::ST_STOP: begin
          if (s_reg.txTick == stopTicks(s_reg.frame_format_control) - 6'h01) begin
            s_next.txTick = 6'h00;
            s_next.txState = asce_pkg::ST_IDLE;
          end
        end
        default: s_next.txState = asce_pkg::ST_IDLE;
      endcase
    end
    if (s_reg.tick) begin
      s_next.rxTick = s_reg.rxTick + 6'h01;
      case (s_reg.rxState)
        asce_pkg::ST_IDLE: begin
          s_next.rxTick = 6'h00;
          if (rxIn) begin
            s_next.rxArmed = 1'b1;
          end else if (s_reg.rxArmed) begin
            s_next.rxArmed = 1'b0;
            s_next.rxState = asce_pkg::ST_START;
          end
        end
        asce_pkg::ST_START: begin
          // Mid-start check rejects glitches
          if (s_reg.rxTick == asce_pkg::TICK_HALF - 6'h01) begin
            s_next.rxTick = 6'h00;
            s_next.rxState = rxIn ? asce_pkg::ST_IDLE : asce_pkg::ST_DATA;
            s_next.rxArmed = rxIn;
            s_next.rxIdx = 3'h0;
            s_next.rxPar = 1'b0;
            s_next.rxPerr = 1'b0;
            s_next.rxAllZero = 1'b1;
          end
        end
        asce_pkg::ST_DATA: begin
          if (rxMid) begin
            s_next.rxTick = 6'h00;
            s_next.rxShift = {rxIn, s_reg.rxShift[7:1]};
            s_next.rxPar = s_reg.rxPar ^ rxIn;
            s_next.rxAllZero = s_reg.rxAllZero & ~rxIn;
            s_next.rxIdx = s_reg.rxIdx + 3'h1;
            if (s_reg.rxIdx == lastIdx) begin
              s_next.rxState = s_reg.frame_format_control[asce_pkg::LCR_PEN] ? asce_pkg::ST_PAR : asce_pkg::ST_STOP;
            end
          end
        end
        asce_pkg::ST_PAR: begin
          if (rxMid) begin
            s_next.rxTick = 6'h00;
            s_next.rxPerr = (rxIn != parityBit(s_reg.rxPar, s_reg.frame_format_control));
            s_next.rxAllZero = s_reg.rxAllZero & ~rxIn;
            s_next.rxState = asce_pkg::ST_STOP;
          end
        end
        asce_pkg::ST_STOP: begin
          if (rxMid) begin
            s_next.rxTick = 6'h00;
            s_next.rxState = asce_pkg::ST_IDLE;
            rxPush = 1'b1;
            rxPushData = s_reg.rxShift >> (3'h7 - lastIdx);
            s_next.fe = s_next.fe | ~rxIn;
            s_next.pe = s_next.pe | s_reg.rxPerr;
            s_next.bi = s_next.bi | (s_reg.rxAllZero & ~rxIn);
            s_next.oe = s_next.oe | ~fifoReady;
          end
        end
        default: s_next.rxState = asce_pkg::ST_IDLE;
      endcase
    end
    if (busReq.wr) begin
      case (busReq.addr)
        asce_pkg::OFS_DATA: begin
          if (divisor_bank_select) begin
            s_next.dll = busReq.wdata;
          end else begin
            s_next.transmit_holding = busReq.wdata;
            s_next.thrFull = 1'b1;
            s_next.threIrq = 1'b0;
          end
        end
        asce_pkg::OFS_IER: begin
          if (divisor_bank_select) begin
            s_next.dlm = busReq.wdata;
          end else begin
            s_next.interrupt_enable = busReq.wdata[3:0];
            if (busReq.wdata[asce_pkg::IER_TX_HOLDING_EMPTY] && !s_reg.interrupt_enable[asce_pkg::IER_TX_HOLDING_EMPTY]
                && !s_next.thrFull) begin
              s_next.threIrq = 1'b1;
            end
          end
        end
        asce_pkg::OFS_LCR: s_next.frame_format_control = busReq.wdata;
        asce_pkg::OFS_MCR: s_next.handshake_output_control = busReq.wdata[4:0];
        asce_pkg::OFS_SCR: s_next.scr = busReq.wdata;
        default: s_next.scr = s_reg.scr;
      endcase
    end
    s_next.txdPin = loop | (~s_reg.frame_format_control[asce_pkg::LCR_BRK] & s_reg.txLine);
    s_next.dtrPin = s_reg.handshake_output_control[asce_pkg::MCR_DTR] & ~loop;
    s_next.rtsPin = s_reg.handshake_output_control[asce_pkg::MCR_RTS] & ~loop;
    s_next.out1Pin = s_reg.handshake_output_control[asce_pkg::MCR_OUT1] & ~loop;
    s_next.out2Pin = s_reg.handshake_output_control[asce_pkg::MCR_OUT2] & ~loop;
    s_next.irqPin = s_reg.handshake_output_control[asce_pkg::MCR_OUT2] & pending;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= asce_pkg::TOP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busRdata = s_reg.rdata;
  assign irqOut = s_reg.irqPin;
  assign serialOut = s_reg.txdPin;
  assign dtrOut = s_reg.dtrPin;
  assign rtsOut = s_reg.rtsPin;
  assign out1Out = s_reg.out1Pin;
  assign out2Out = s_reg.out2Pin;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_startLow;
    s_reg.txState == asce_pkg::ST_START |-> !s_reg.txLine;
  endproperty
  a_startLow: assert property (p_startLow) else $error("start bit not low");
  property p_baudThree;
    (s_reg.tick && divisor == 16'h0003 && !busReq.wr) ##1 (!busReq.wr) |-> !s_reg.tick ##1 !s_reg.tick ##1 s_reg.tick;
  endproperty
  a_baudThree: assert property (p_baudThree) else $error("tick period wrong");
  property p_thrLoad;
    busReq.wr && busReq.addr == asce_pkg::OFS_DATA && !divisor_bank_select |=> s_reg.thrFull && s_reg.transmit_holding == $past(busReq.wdata);
  endproperty
  a_thrLoad: assert property (p_thrLoad) else $error("holding load failed");
  property p_divRead;
    busReq.rd && busReq.addr == asce_pkg::OFS_DATA && divisor_bank_select |=> busRdata == $past(s_reg.dll);
  endproperty
  a_divRead: assert property (p_divRead) else $error("divisor low readback wrong");
  property p_ierRead;
    busReq.rd && busReq.addr == asce_pkg::OFS_IER && !divisor_bank_select |=> busRdata == {4'h0, $past(s_reg.interrupt_enable)};
  endproperty
  a_ierRead: assert property (p_ierRead) else $error("enable readback wrong");
  property p_iirRead;
    busReq.rd && busReq.addr == asce_pkg::OFS_IIR |=> busRdata[7:3] == 5'h00 && busRdata[0] == !$past(pending);
  endproperty
  a_iirRead: assert property (p_iirRead) else $error("source register wrong");
  property p_lsrRead;
    busReq.rd && busReq.addr == asce_pkg::OFS_LSR |=> !busRdata[7] && busRdata[6] == $past(tx_shifter_empty);
  endproperty
  a_lsrRead: assert property (p_lsrRead) else $error("line status layout wrong");
  property p_lsrClear;
    busReq.rd && busReq.addr == asce_pkg::OFS_LSR && !rxPush |=> !s_reg.oe && !s_reg.pe && !s_reg.fe && !s_reg.bi;
  endproperty
  a_lsrClear: assert property (p_lsrClear) else $error("error flags not cleared");
  property p_priority;
    busReq.rd && busReq.addr == asce_pkg::OFS_IIR && pendLine
      |=> busRdata == {5'h00, asce_pkg::IID_LINE, 1'b0};
  endproperty
  a_priority: assert property (p_priority) else $error("line status not highest");
  property p_loopIdle;
    loop [*2] |-> serialOut && !dtrOut && !rtsOut;
  endproperty
  a_loopIdle: assert property (p_loopIdle) else $error("outputs active in loopback");
  property p_irqGate;
    !s_reg.handshake_output_control[asce_pkg::MCR_OUT2] [*2] |-> !irqOut;
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("request without output two");

  c_txFrame: cover property (s_reg.txState == asce_pkg::ST_STOP ##1 s_reg.txState == asce_pkg::ST_IDLE);
  c_rxByte: cover property (rxPush && fifoReady);
  c_overrun: cover property (rxPush && !fifoReady);
  c_irq: cover property ($rose(irqOut));
endmodule : asce_uart

`default_nettype wire

// ==== verification/asce_peer.sv ====
// Serial line peer that sends frames to the element and decodes its frames
`timescale 1ns/10ps
`default_nettype none
module asce_peer #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1;
  task automatic send(input logic [7:0] d, input logic stp);
    @(negedge clk);
    lineOut = 1'b0;
    repeat (BIT) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      lineOut = d[i];
      repeat (BIT) @(negedge clk);
    end
    lineOut = stp;
    repeat (BIT) @(negedge clk);
    lineOut = 1'b1;
  endtask : send
  task automatic recv(input int nb, input logic parity_on, output logic [7:0] d,
                      output logic p, output logic ok);
    int n;
    d = '0;
    p = 1'b0;
    n = 0;
    while (lineIn !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    repeat (BIT / 2) @(negedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(negedge clk);
      d[i] = lineIn;
    end
    if (parity_on) begin
      repeat (BIT) @(negedge clk);
      p = lineIn;
    end
    repeat (BIT) @(negedge clk);
    ok = (n < 4000) && (lineIn === 1'b1);
  endtask : recv
endmodule : asce_peer
`default_nettype wire

// ==== verification/tb_asce_uart.sv ====
// Self-checking bench of the serial communication element
`timescale 1ns/10ps
`default_nettype none
module tb_asce_uart;
  logic clk = 1'b0;
  logic rst_b;
  asce_pkg::asce_bus_req_t busReq;
  asce_pkg::asce_modem_in_t modemIn;
  logic [7:0] busRdata;
  logic irqOut, serialOut, serialIn, dtrOut, rtsOut, out1Out, out2Out;
  int miscompares;
  int samplesChecked;
  logic [7:0] rxQ[$];
  logic [7:0] fmt[8] = '{8'h04, 8'h05, 8'h02, 8'h07, 8'h1b, 8'h0b, 8'h2b, 8'h3b};
  logic [3:0] mIn[3] = '{4'hb, 4'hf, 4'h0};
  logic [7:0] mExp[3] = '{8'hbb, 8'hf0, 8'h0f};
  asce_uart #(.FIFO_DEPTH(8)) DUT (.clk(clk), .rst_b(rst_b), .busReq(busReq),
    .busRdata(busRdata), .irqOut(irqOut), .serialOut(serialOut), .serialIn(serialIn),
    .dtrOut(dtrOut), .rtsOut(rtsOut), .out1Out(out1Out), .out2Out(out2Out),
    .modemIn(modemIn));
  asce_peer #(.BIT(16)) peer (.clk(clk), .lineIn(serialOut), .lineOut(serialIn));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    busReq = {1'b1, 1'b0, a, d};
    @(negedge clk);
    busReq = '0;
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clk);
    busReq = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    busReq = '0;
    ck(busRdata, exp);
  endtask : rc
  task automatic results();
    $display("Checked %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    #800000;
    miscompares++;
    results();
  end
  initial begin
    logic [7:0] d, r, m;
    logic p, ok;
    int nb, st;
    busReq = '0;
    modemIn = '0;
    rst_b = 1'b0;
    miscompares = 0;
    samplesChecked = 0;
    void'($urandom(32'h6124_6b33));
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    rc(3'h5, 8'h60);
    rc(3'h2, 8'h01);
    r = 8'($urandom);
    wr(3'h7, r);
    rc(3'h7, r);
    wr(3'h2, 8'hff);
    rc(3'h2, 8'h01);
    wr(3'h1, 8'h0a);
    rc(3'h1, 8'h0a);
    ck({7'h0, irqOut}, 8'h00);
    rc(3'h2, 8'h02);
    rc(3'h2, 8'h01);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h03);
    wr(3'h1, 8'h00);
    rc(3'h1, 8'h00);
    rc(3'h0, 8'h03);
    repeat (12) @(negedge clk);
    wr(3'h0, 8'h01);
    rc(3'h0, 8'h01);
    wr(3'h3, 8'h03);
    rc(3'h1, 8'h0a);
    wr(3'h1, 8'h00);
    $display("Registers test done");
    foreach (fmt[i]) begin
      nb = int'(fmt[i][1:0]) + 5;
      st = fmt[i][2] ? ((nb == 5) ? 24 : 32) : 16;
      wr(3'h3, fmt[i]);
      r = 8'($urandom);
      m = r & (8'hff >> (8 - nb));
      wr(3'h0, r);
      peer.recv(nb, fmt[i][3], d, p, ok);
      ck({7'h0, ok}, 8'h01);
      ck(d, m);
      if (fmt[i][3])
        ck({7'h0, p}, {7'h0, fmt[i][5] ? ~fmt[i][4] : ^m ^ ~fmt[i][4]});
      // Shifter still busy just before stop end
      repeat (st - 12) @(negedge clk);
      rc(3'h5, 8'h20);
      @(negedge clk);
      rc(3'h5, 8'h60);
    end
    rc(3'h5, 8'h60);
    wr(3'h3, 8'h43);
    repeat (2) @(negedge clk);
    ck({7'h0, serialOut}, 8'h00);
    wr(3'h3, 8'h03);
    $display("Transmit test done");
    wr(3'h1, 8'h01);
    wr(3'h4, 8'h0f);
    r = 8'($urandom);
    peer.send(r, 1'b1);
    repeat (4) @(negedge clk);
    ck({7'h0, irqOut}, 8'h01);
    rc(3'h2, 8'h04);
    rc(3'h0, r);
    repeat (3) @(negedge clk);
    ck({7'h0, irqOut}, 8'h00);
    ck({4'h0, out2Out, out1Out, rtsOut, dtrOut}, 8'h0f);
    wr(3'h1, 8'h05);
    for (int i = 0; i < 9; i++) begin
      r = 8'($urandom);
      rxQ.push_back(r);
      peer.send(r, 1'b1);
    end
    rc(3'h2, 8'h06);
    rc(3'h5, 8'h63);
    rc(3'h5, 8'h61);
    rc(3'h2, 8'h04);
    for (int i = 0; i < 8; i++) rc(3'h0, rxQ[i]);
    rc(3'h5, 8'h60);
    // Break: all zero including stop
    peer.send(8'h00, 1'b0);
    repeat (4) @(negedge clk);
    rc(3'h5, 8'h79);
    rc(3'h0, 8'h00);
    // Even parity, peer stop lands on parity slot
    wr(3'h3, 8'h1b);
    r = 8'($urandom);
    peer.send(r, 1'b1);
    repeat (20) @(negedge clk);
    rc(3'h5, {5'h0c, ~^r, 2'h1});
    rc(3'h0, r);
    wr(3'h3, 8'h03);
    $display("Receive test done");
    wr(3'h1, 8'h08);
    foreach (mIn[i]) begin
      modemIn = asce_pkg::asce_modem_in_t'(mIn[i]);
      repeat (3) @(negedge clk);
      rc(3'h2, {7'h0, mExp[i][3:0] == 4'h0});
      rc(3'h6, mExp[i]);
      rc(3'h6, mExp[i] & 8'hf0);
    end
    wr(3'h4, 8'h13);
    repeat (3) @(negedge clk);
    rc(3'h6, 8'h33);
    r = 8'($urandom);
    wr(3'h0, r);
    repeat (200) @(negedge clk);
    rc(3'h0, r);
    ck({6'h0, serialOut, dtrOut}, 8'h02);
    $display("Handshake test done");
    results();
  end
endmodule : tb_asce_uart
`default_nettype wire
